//--- bench/rtc_twi_port_sva.sv
// Concurrent checks on the pins of the two-wire target port.
module rtc_twi_port_sva
	import rtc_twi_pkg::*;
(
	input wire logic       core_clk_in,
	input wire logic       rstn_in,
	input wire logic       ce_in,
	input wire logic       scl_in,
	input wire logic       sda_in,
	input wire logic       sda_out,
	input wire logic       sda_oe_out,
	input wire logic [7:0] rd_addr_out,
	input wire logic [7:0] rd_data_in,
	input wire logic       wr_valid_out,
	input wire logic       wr_ready_in,
	input wire wr_entry_s  wr_entry_out
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] up_cnt;
	// Saturates, so it also spans the first transfer that the bench aims into power-up.
	always_ff @(posedge core_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			up_cnt <= 8'h00;
		end else if (up_cnt != 8'hFF) begin
			up_cnt <= up_cnt + 8'h01;
		end
	end
	default clocking @(posedge core_clk_in); endclocking
	default disable iff (!rstn_in);
	sequence s_hold;
		sda_oe_out [*8];
	endsequence
	sequence s_stop;
		scl_in && $past(scl_in) && $rose(sda_in);
	endsequence
	a_drive_level: assert property (sda_out == 1'b0)
		else $error("data drive level not low");
	a_powerup_quiet: assert property (up_cnt != 8'hFF |-> !sda_oe_out && !wr_valid_out)
		else $error("activity during power-up");
	a_oe_scl_low: assert property ($changed(sda_oe_out) |-> !scl_in && !$past(scl_in))
		else $error("data drive changed with clock high");
	a_ack_hold: assert property ($rose(sda_oe_out) |-> s_hold)
		else $error("data drive too short");
	a_stop_idle: assert property (s_stop |-> !sda_oe_out)
		else $error("data driven at stop");
	a_valid_hold: assert property (wr_valid_out && !wr_ready_in |=> wr_valid_out)
		else $error("commit dropped");
	a_entry_hold: assert property (wr_valid_out && !wr_ready_in |=> $stable(wr_entry_out))
		else $error("commit entry changed");
	a_ptr_reset: assert property ($rose(rstn_in) |-> rd_addr_out == PTR_RESET)
		else $error("pointer not zero after reset");
	a_commit_idle: assert property ($rose(wr_valid_out) |-> scl_in && sda_in)
		else $error("commit before stop");
	a_ce_freeze: assert property (!ce_in |=> $stable(sda_oe_out) && $stable(rd_addr_out) && $stable(wr_valid_out) && $stable(wr_entry_out))
		else $error("state moved with clock enable low");
endmodule

//--- bench/tb_rtc_two_wire_target_port.sv
// Self-checking bench for the two-wire target port.
module tb_rtc_two_wire_target_port;
	import rtc_twi_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	logic       core_clk_in = 1'b0;
	logic       rstn_in     = 1'b0;
	logic       scl, ctl_sda, sda_out, sda_oe_out, wr_valid_out, ok;
	logic       stall       = 1'b0;
	logic       ce_in       = 1'b1;
	logic       wr_ready_in = 1'b0;
	logic [7:0] rd_data_in  = 8'h00;
	logic [7:0] seed        = 8'h26;
	logic [7:0] rd_addr_out;
	logic [8:0] q;
	wr_entry_s  wr_entry_out;
	wr_entry_s  exp_q[$];
	int         n_mismatch  = 0;
	int         n_tests     = 0;
	// Open drain with pull-up: released unless someone pulls low.
	wire sda_w = ctl_sda & (sda_oe_out ? sda_out : 1'b1);
	twi_ctl i_twi_ctl (.clk_in(core_clk_in), .sda_in(sda_w), .scl_out(scl), .sda_out(ctl_sda));
	rtc_two_wire_target_port i_rtc_two_wire_target_port (.core_clk_in(core_clk_in),
		.rstn_in(rstn_in), .ce_in(ce_in), .scl_in(scl), .sda_in(sda_w), .sda_out(sda_out),
		.sda_oe_out(sda_oe_out), .rd_addr_out(rd_addr_out), .rd_data_in(rd_data_in),
		.wr_valid_out(wr_valid_out), .wr_ready_in(wr_ready_in), .wr_entry_out(wr_entry_out));
	function automatic logic [7:0] lfsr(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction
	task automatic chk(input logic [15:0] seen, input logic [15:0] want);
		n_tests++;
		if (seen !== want) begin
			n_mismatch++;
			$display("unexpected at %0t ns: saw %h wanted %h", $time, seen, want);
		end
	endtask
	task automatic stop_test();
		$display("checks %0d mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		i_twi_ctl.start();
		i_twi_ctl.byte_x({TARGET_ADDR, 1'b0, 1'b1}, q);
		ok = !q[0];
		i_twi_ctl.byte_x({a, 1'b1}, q);
		if (ok) begin
			chk(q[0], 1'b0);
		end
		i_twi_ctl.byte_x({d, 1'b1}, q);
		if (ok) begin
			chk(q[0], 1'b0);
			exp_q.push_back({a, d});
		end
		i_twi_ctl.stop();
	endtask
	// With rnd set, the target address goes out twice, write then read; stop after the nack.
	task automatic rd(input logic [7:0] a, input logic rnd, input int n);
		i_twi_ctl.start();
		if (rnd) begin
			i_twi_ctl.byte_x({TARGET_ADDR, 1'b0, 1'b1}, q);
			chk(q[0], 1'b0);
			i_twi_ctl.byte_x({a, 1'b1}, q);
			chk(q[0], 1'b0);
			i_twi_ctl.start();
		end
		i_twi_ctl.byte_x({TARGET_ADDR, DIR_READ, 1'b1}, q);
		chk(q[0], 1'b0);
		for (int i = 0; i < n; i++) begin
			i_twi_ctl.byte_x({8'hFF, i == n - 1}, q);
			chk(q[8:1], (a + i[7:0]) ^ 8'hA5);
		end
		i_twi_ctl.stop();
	endtask
	initial begin
		forever #5 core_clk_in = ~core_clk_in;
	end
	// The register array answers with a fixed scramble of the address.
	always @(posedge core_clk_in) begin
		seed <= lfsr(seed);
		wr_ready_in <= !stall && seed[0];
		rd_data_in <= rd_addr_out ^ 8'hA5;
	end
	always @(posedge core_clk_in) begin
		if (wr_valid_out === 1'b1 && wr_ready_in === 1'b1 && ce_in === 1'b1) begin
			if (exp_q.size() == 0) begin
				n_mismatch++;
				$display("unexpected at %0t ns: spurious commit", $time);
			end else begin
				chk(wr_entry_out, exp_q.pop_front());
			end
		end
	end
	initial begin
		repeat (60000) @(posedge core_clk_in);
		n_mismatch++;
		$display("unexpected at %0t ns: run timed out", $time);
		stop_test();
	end
	initial begin
		repeat (12) @(posedge core_clk_in);
		rstn_in <= 1'b1;
		i_twi_ctl.start();
		i_twi_ctl.byte_x({TARGET_ADDR, 1'b0, 1'b1}, q);
		chk(q[0], 1'b1);
		i_twi_ctl.stop();
		rd(PTR_RESET, 1'b0, 1);
		for (int k = 0; k < 3; k++) begin
			wr(seed, lfsr(seed));
			chk(ok, 1'b1);
			rd(exp_q[$].addr, 1'b0, 1);
			rd(seed, 1'b1, 3);
		end
		// Flip each target address bit in turn; none may be answered.
		for (int k = 0; k < 7; k++) begin
			i_twi_ctl.start();
			i_twi_ctl.byte_x({TARGET_ADDR ^ (7'h01 << k), 1'b1, 1'b1}, q);
			chk(q[0], 1'b1);
			i_twi_ctl.stop();
		end
		// A stalled consumer must eventually make the port refuse writes.
		stall <= 1'b1;
		for (int k = 0; k < 40; k++) begin
			wr(seed, lfsr(seed));
		end
		chk(ok, 1'b0);
		stall <= 1'b0;
		// A low clock enable must hold the full commit queue untouched.
		ce_in <= 1'b0;
		repeat (32) @(posedge core_clk_in);
		chk(wr_valid_out, 1'b1);
		ce_in <= 1'b1;
		for (int k = 0; k < 4000 && exp_q.size() > 0; k++) begin
			@(posedge core_clk_in);
		end
		chk(exp_q.size(), 16'h0000);
		stop_test();
	end
endmodule
bind rtc_two_wire_target_port rtc_twi_port_sva i_rtc_twi_port_sva (.core_clk_in(core_clk_in),
	.rstn_in(rstn_in), .ce_in(ce_in), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out),
	.sda_oe_out(sda_oe_out), .rd_addr_out(rd_addr_out), .rd_data_in(rd_data_in),
	.wr_valid_out(wr_valid_out), .wr_ready_in(wr_ready_in), .wr_entry_out(wr_entry_out));

//--- bench/twi_ctl.sv
// Behavioural two-wire bus controller; a released data line reads high.
module twi_ctl (
	input  wire logic clk_in,
	input  wire logic sda_in,
	output logic      scl_out,
	output logic      sda_out
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		scl_out = 1'b1;
		sda_out = 1'b1;
	end
	// Lines move a quarter period apart, data with clock low except at start and stop.
	task automatic step(input logic c, input logic d);
		scl_out <= c;
		sda_out <= d;
		repeat (4) @(posedge clk_in);
	endtask
	task automatic start();
		step(1'b0, sda_out);
		step(1'b0, 1'b1);
		step(1'b1, 1'b1);
		step(1'b1, 1'b0);
	endtask
	// Stop, then an idle gap with the clock standing high.
	task automatic stop();
		step(1'b0, sda_out);
		step(1'b0, 1'b0);
		step(1'b1, 1'b0);
		step(1'b1, 1'b1);
		step(1'b1, 1'b1);
	endtask
	// Eight bits msb first, then the ninth acknowledge clock.
	task automatic byte_x(input logic [8:0] d, output logic [8:0] q);
		for (int i = 8; i >= 0; i--) begin
			step(1'b0, sda_out);
			step(1'b0, d[i]);
			step(1'b1, d[i]);
			q[i] = sda_in;
			step(1'b1, d[i]);
		end
	endtask
endmodule

//--- rtl/rtc_twi_pkg.sv
// Shared constants and carrier types for the two-wire register port.
package rtc_twi_pkg;
	localparam int          CLK_PERIOD_NS  = 10;
	localparam int          POWERUP_NS     = 1000;
	localparam int          POWERUP_CYCLES = (POWERUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [6:0]  TARGET_ADDR    = 7'h68;
	localparam logic [7:0]  PTR_RESET      = 8'h00;
	localparam logic [3:0]  BYTE_BITS      = 4'h8;
	localparam int          WR_FIFO_DEPTH  = 32;
	localparam logic        DIR_READ       = 1'b1;

	typedef enum logic [2:0] {
		ST_IDLE  = 3'b000,
		ST_DEV   = 3'b001,
		ST_WORD  = 3'b010,
		ST_WDATA = 3'b011,
		ST_RDATA = 3'b100,
		ST_ACK   = 3'b101,
		ST_MACK  = 3'b110
	} port_state_e;

	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] data;
	} wr_entry_s;
endpackage

//--- rtl/rtc_two_wire_target_port.sv
// Target-side two-wire serial port onto the clock/control register array.
// Behaviour
// RULE1: Bytes shift most significant bit first in both directions.
// RULE2: Data changes only with clock low; changes with clock high are start/stop.
// RULE3: After power-up the data line is released until a transfer needs driving.
// RULE4: Falling data with clock high starts a transfer; all else ignored before it.
// RULE5: Starts seen during the power-up sequence are ignored.
// RULE6: Rising data with clock high stops a transfer and returns to standby.
// RULE7: After eight bits the sender releases data; receiver pulls low on ninth.
// RULE8: Acknowledge a matching target address, the word address and written data; a write address gets no ack while the commit queue is full.
// RULE9: Keep sending read bytes while the controller acknowledges each one.
// RULE10: Upper seven bits of the first byte must equal 1101000.
// RULE11: Lowest bit of the first byte: one reads, zero writes.
// RULE12: Compare the full received address byte and acknowledge only on match; the code compares only bits 7:1.
// RULE13: One word address byte follows; otherwise the internal counter is used.
// RULE14: The internal address counter is zero after power-up.
// RULE15: Controller repeats the same target address in a random read.
// RULE16: Written data reaches the register array only at the stop.
// RULE17: After a write the pointer stays at the last written location.
// RULE18: Controller reads by writing a word address, repeated start, then reading.
// RULE19: Read data comes from the pointer, loaded by the address and incremented.
// RULE20: Controller ends a read with a stop after the last wanted byte.
// RULE21: On an address mismatch keep data released and wait for the next start.
module rtc_two_wire_target_port
	import rtc_twi_pkg::*;
(
	input  wire logic       core_clk_in,
	input  wire logic       rstn_in,
	input  wire logic       ce_in,
	input  wire logic       scl_in,
	input  wire logic       sda_in,
	output logic            sda_out,
	output logic            sda_oe_out,
	output logic [7:0]      rd_addr_out,
	input  wire logic [7:0] rd_data_in,
	output logic            wr_valid_out,
	input  wire logic       wr_ready_in,
	output wr_entry_s       wr_entry_out
);
	typedef struct packed {
		logic        scl_meta;
		logic        scl_s;
		logic        scl_q;
		logic        sda_meta;
		logic        sda_s;
		logic        sda_q;
		logic [7:0]  pwr_cnt;
		port_state_e state;
		port_state_e after_ack;
		logic [7:0]  sh;
		logic [3:0]  cnt;
		logic [7:0]  ptr;
		logic        mack;
		logic        sda_oe;
		logic        pend_valid;
		wr_entry_s   pend;
		logic        push_valid;
	} core_state_s;

	core_state_s r;
	core_state_s next_r;
	logic        fifo_in_ready;
	logic        rise;
	logic        fall;
	logic        start_seen;
	logic        stop_seen;
	logic        byte_done;

	// The pin is open drain: the driven level is always low, only the enable moves.
	assign sda_out     = 1'b0;
	assign sda_oe_out  = r.sda_oe;
	assign rd_addr_out = r.ptr;

	always_comb begin
		next_r = r;
		next_r.scl_meta = scl_in;
		next_r.scl_s    = r.scl_meta;
		next_r.scl_q    = r.scl_s;
		next_r.sda_meta = sda_in;
		next_r.sda_s    = r.sda_meta;
		next_r.sda_q    = r.sda_s;

		rise       = r.scl_s && !r.scl_q;
		fall       = !r.scl_s && r.scl_q;
		// RULE2: data edges during clock high
		start_seen = r.scl_s && r.scl_q && r.sda_q && !r.sda_s;
		stop_seen  = r.scl_s && r.scl_q && !r.sda_q && r.sda_s;
		byte_done  = (r.cnt == BYTE_BITS);

		// RULE5: power-up hold-off count
		if (r.pwr_cnt != 8'h00) begin
			next_r.pwr_cnt = r.pwr_cnt - 8'h01;
		end
		if (r.push_valid && fifo_in_ready) begin
			next_r.push_valid = 1'b0;
		end

		if (stop_seen) begin
			// RULE6: stop returns to standby
			next_r.state  = ST_IDLE;
			next_r.sda_oe = 1'b0;
			// RULE16: commit held write at stop
			if (r.pend_valid) begin
				next_r.push_valid = 1'b1;
				next_r.pend_valid = 1'b0;
			end
		end else if (start_seen && r.pwr_cnt == 8'h00) begin
			// RULE4: start opens address phase
			next_r.state      = ST_DEV;
			next_r.cnt        = 4'h0;
			next_r.sda_oe     = 1'b0;
			next_r.pend_valid = 1'b0;
		end else begin
			unique case (r.state)
				ST_IDLE: begin
					next_r.sda_oe = 1'b0;
				end
				ST_DEV, ST_WORD, ST_WDATA: begin
					if (rise && !byte_done) begin
						// RULE1: shift in msb first
						next_r.sh  = {r.sh[6:0], r.sda_s};
						next_r.cnt = r.cnt + 4'h1;
					end else if (fall && byte_done) begin
						next_r.cnt = 4'h0;
						if (r.state == ST_DEV) begin
							// RULE10: compare upper seven bits
							// RULE12: acknowledge only on match
							if (r.sh[7:1] != TARGET_ADDR) begin
								// RULE21: mismatch stays released
								next_r.state = ST_IDLE;
							end else if (r.sh[0] == DIR_READ) begin
								// RULE11: direction bit selects read
								next_r.state     = ST_ACK;
								next_r.after_ack = ST_RDATA;
								next_r.sda_oe    = 1'b1;
							end else if (!r.push_valid && fifo_in_ready) begin
								// RULE8: acknowledge write address
								next_r.state     = ST_ACK;
								next_r.after_ack = ST_WORD;
								next_r.sda_oe    = 1'b1;
							end else begin
								// A full commit queue, or a commit still waiting to enter it, refuses the write by withholding the ack.
								next_r.state = ST_IDLE;
							end
						end else if (r.state == ST_WORD) begin
							// RULE13: word address loads pointer
							next_r.ptr       = r.sh;
							next_r.state     = ST_ACK;
							next_r.after_ack = ST_WDATA;
							next_r.sda_oe    = 1'b1;
						end else begin
							// RULE17: pointer stays on written byte
							next_r.pend_valid = 1'b1;
							next_r.pend.addr  = r.ptr;
							next_r.pend.data  = r.sh;
							next_r.state      = ST_ACK;
							next_r.after_ack  = ST_WDATA;
							next_r.sda_oe     = 1'b1;
						end
					end
				end
				ST_ACK: begin
					// RULE7: release after the ninth clock
					if (fall) begin
						next_r.state  = r.after_ack;
						next_r.sda_oe = 1'b0;
						if (r.after_ack == ST_RDATA) begin
							// RULE19: read from the pointer
							next_r.sh     = rd_data_in;
							next_r.sda_oe = !rd_data_in[7];
						end
					end
				end
				ST_RDATA: begin
					if (rise) begin
						next_r.cnt = r.cnt + 4'h1;
					end else if (fall) begin
						if (byte_done) begin
							// RULE19: advance pointer per byte sent
							next_r.ptr    = r.ptr + 8'h01;
							next_r.sda_oe = 1'b0;
							next_r.state  = ST_MACK;
							next_r.cnt    = 4'h0;
						end else begin
							// RULE1: shift out msb first
							next_r.sh     = {r.sh[6:0], 1'b0};
							next_r.sda_oe = !r.sh[6];
						end
					end
				end
				ST_MACK: begin
					if (rise) begin
						next_r.mack = !r.sda_s;
					end else if (fall) begin
						// RULE9: continue only on controller ack
						if (r.mack) begin
							next_r.state  = ST_RDATA;
							next_r.sh     = rd_data_in;
							next_r.sda_oe = !rd_data_in[7];
						end else begin
							next_r.state = ST_IDLE;
						end
					end
				end
				default: begin
					next_r.state  = ST_IDLE;
					next_r.sda_oe = 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge core_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			r          <= '0;
			r.scl_meta <= 1'b1;
			r.scl_s    <= 1'b1;
			r.scl_q    <= 1'b1;
			r.sda_meta <= 1'b1;
			r.sda_s    <= 1'b1;
			r.sda_q    <= 1'b1;
			r.pwr_cnt  <= 8'(POWERUP_CYCLES);
			r.state    <= ST_IDLE;
			r.after_ack <= ST_IDLE;
			// RULE14: pointer starts at zero
			r.ptr      <= PTR_RESET;
			// RULE3: data line released at power-up
			r.sda_oe   <= 1'b0;
		end else if (ce_in) begin
			r <= next_r;
		end
	end

	wr_fifo #(
		.WIDTH ($bits(wr_entry_s)),
		.DEPTH (WR_FIFO_DEPTH)
	) i_wr_fifo (
		.clk_in        (core_clk_in),
		.rstn_in       (rstn_in),
		.ce_in         (ce_in),
		.in_valid_in   (r.push_valid),
		.in_ready_out  (fifo_in_ready),
		.in_data_in    (r.pend),
		.out_valid_out (wr_valid_out),
		.out_ready_in  (wr_ready_in),
		.out_data_out  (wr_entry_out)
	);
endmodule

//--- rtl/wr_fifo.sv
// Write-commit FIFO with a registered output stage.
module wr_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 32
) (
	input  wire logic             clk_in,
	input  wire logic             rstn_in,
	input  wire logic             ce_in,
	input  wire logic             in_valid_in,
	output logic                  in_ready_out,
	input  wire logic [WIDTH-1:0] in_data_in,
	output logic                  out_valid_out,
	input  wire logic             out_ready_in,
	output logic [WIDTH-1:0]      out_data_out
);
	localparam int AW = $clog2(DEPTH);

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW-1:0]               wp;
		logic [AW-1:0]               rp;
		logic [AW:0]                 count;
		logic                        out_valid;
		logic [WIDTH-1:0]            out_data;
	} fifo_state_s;

	fifo_state_s r;
	fifo_state_s next_r;
	logic        push;
	logic        pop;

	assign in_ready_out  = (r.count != (AW + 1)'(DEPTH));
	assign out_valid_out = r.out_valid;
	assign out_data_out  = r.out_data;

	always_comb begin
		next_r = r;
		push   = in_valid_in && in_ready_out;
		pop    = (r.count != '0) && (!r.out_valid || out_ready_in);
		if (out_ready_in) begin
			next_r.out_valid = 1'b0;
		end
		// The output stage refills in the same cycle it drains, so a full stream never bubbles.
		if (pop) begin
			next_r.out_data  = r.mem[r.rp];
			next_r.out_valid = 1'b1;
			next_r.rp        = r.rp + 1'b1;
		end
		if (push) begin
			next_r.mem[r.wp] = in_data_in;
			next_r.wp        = r.wp + 1'b1;
		end
		next_r.count = r.count + (AW + 1)'(push) - (AW + 1)'(pop);
	end

	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			r <= '0;
		end else if (ce_in) begin
			r <= next_r;
		end
	end
endmodule
